//--- hw/bim_irq_top.sv
// Purpose: Interrupt enables, status, routing and open-drain pins
// Assumes: AXI4-Lite slave, 32-bit data, source events on aclk
// Notes: Pins only pull low; the board pull-up makes the high level
// Operation
// - Source drives pin only while enabled, except doorbells, which drive once set, and the host queue, which drives while its bit is clear
// - All enables read disabled after reset, except the host queue: its bit resets clear, which leaves it unmasked
// - Normal enable register holds normal sources
// - Host queue bit masks instead of enables
// - Writing one to doorbell sets status
// - Error enable register holds error sources
// - Grouped error names expand per partner port
// - Master-detected error marks source port
// - Target-detected error marks destination port
// - Each source has a three-bit routing field
// - Routing field value selects the asserted pin
// - Input pin needs three low edges
// - Pins active low, pull low only
// - Direction bit per pin, input after reset
// - Six DMA sources per channel with enables
// - Write one clears DMA source, permits restart
// - Write one clears DMA summary, releases pin
// - Status sets when active, clear after reset
// - Doorbell status cleared by writing one
// - Mailbox write sets its status bit
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module bim_irq_top
  import bim_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic host_queue_pending,
  input wire logic iop_queue_pending,
  input wire logic [BIM_NUM_DMA*BIM_DMA_SRCS-1:0] dma_events,
  input wire bim_err_event_s [BIM_NUM_PORTS-1:0] err_events,
  input wire logic [BIM_NUM_PINS-1:0] irq_pin_in,
  output logic [BIM_NUM_PINS-1:0] irq_pin_out,
  output logic [BIM_NUM_PINS-1:0] irq_pin_oe
);
  function automatic logic [31:0] byte_mask(input logic [3:0] strb);
    byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : byte_mask

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [31:0] mask);
    merge = (old & ~mask) | (val & mask);
  endfunction : merge

  // One-hot pin select from a routing field
  function automatic logic [BIM_NUM_PINS-1:0] route(input logic [BIM_MAP_W-1:0] field);
    route = BIM_NUM_PINS'(1) << field;
  endfunction : route

  function automatic logic [4:0] err_index(input bim_err_event_s ev);
    logic [1:0] partner;
    logic [4:0] base;
    partner = ev.by_master ? ev.src_port : ev.dst_port;
    base = 5'(BIM_ERR_PER_PORT) * 5'(err_det_port(ev));
    case (ev.kind)
      BIM_KIND_RETRY: err_index = base + 5'(BIM_ERR_RETRY) + 5'(partner);
      BIM_KIND_BUS: err_index = base + 5'(BIM_ERR_BUS) + 5'(partner);
      BIM_KIND_DPAR: err_index = base + 5'(BIM_ERR_DPAR) + 5'(partner);
      default: err_index = base + 5'(BIM_ERR_APAR);
    endcase
  endfunction : err_index

  function automatic logic [1:0] err_det_port(input bim_err_event_s ev);
    err_det_port = ev.by_master ? ev.dst_port : ev.src_port;
  endfunction : err_det_port

  logic [31:0] normal_interrupt_enable;
  logic [31:0] error_interrupt_enable;
  logic [BIM_NUM_MBOX-1:0] mbox_status;
  logic [BIM_NUM_DB-1:0] db_status;
  logic [BIM_NUM_PINS-1:0] pin_status;
  logic [BIM_NUM_DMA-1:0] dma_status;
  logic iop_status;
  logic [BIM_NUM_ERR-1:0] error_status;
  logic [BIM_NUM_PINS-1:0] direction;
  logic [31:0] irq_routing_register [BIM_NUM_MAP];
  logic [31:0] mailbox [BIM_NUM_MBOX];
  logic [BIM_NUM_PINS-1:0] pin_seen_low;
  logic [BIM_NUM_DMA-1:0] chan_irq;
  logic [31:0] dma_rdata [BIM_NUM_DMA];
  logic [BIM_NUM_DMA-1:0] dma_wr;

  bim_wr_state_e wr_state;
  logic aw_held;
  logic w_held;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] wr_mask;
  logic wr_fire;
  logic [31:0] w1;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;
  logic [31:0] normal_status_word;
  logic [31:0] error_status_word;
  logic [BIM_NUM_PINS-1:0] next_drive;

  // Write channel: address and data accepted in either order
  assign wr_fire = aw_held & w_held & (wr_state == BIM_WR_IDLE);
  assign w1 = wr_data & wr_mask;

  // Registered readies; reopen only once the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_awready <= s_axi_awready & ~s_axi_awvalid;
      s_axi_wready <= s_axi_wready & ~s_axi_wvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_mask <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_mask <= byte_mask(s_axi_wstrb);
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && ((a <= BIM_OFS_DIRECTION)
      || (a >= BIM_OFS_MAP_BASE && a < BIM_OFS_MAP_BASE + 8'(4 * BIM_NUM_MAP))
      || (a >= BIM_OFS_DMA_BASE && a < BIM_OFS_DMA_BASE + 8'(4 * BIM_NUM_DMA))
      || (a >= BIM_OFS_MBOX_BASE && a < BIM_OFS_MBOX_BASE + 8'(4 * BIM_NUM_MBOX)));
  endfunction : addr_ok

  assign wr_ok = addr_ok(wr_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= BIM_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BIM_RESP_OKAY;
    end else begin
      case (wr_state)
        BIM_WR_IDLE: begin
          if (wr_fire) begin
            wr_state <= BIM_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? BIM_RESP_OKAY : BIM_RESP_SLVERR;
          end
        end
        BIM_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= BIM_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state <= BIM_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Enable registers; doorbell bits store nothing and read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      normal_interrupt_enable <= BIM_RST_WORD;
      error_interrupt_enable <= BIM_RST_WORD;
    end else if (wr_fire && wr_addr == BIM_OFS_NORMAL_EN) begin
      normal_interrupt_enable <= merge(normal_interrupt_enable, wr_data, wr_mask)
        & ~(32'((1 << BIM_NUM_DB) - 1) << BIM_POS_DB)
        & ~(32'h1 << BIM_POS_ERR_ACTV);
    end else if (wr_fire && wr_addr == BIM_OFS_ERROR_EN) begin
      error_interrupt_enable <= merge(error_interrupt_enable, wr_data, wr_mask)
        & 32'((1 << BIM_NUM_ERR) - 1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      direction <= '0;
    end else if (wr_fire && wr_addr == BIM_OFS_DIRECTION) begin
      direction <= BIM_NUM_PINS'(merge(32'(direction), wr_data, wr_mask));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < BIM_NUM_MAP; i++) begin
        irq_routing_register[i] <= BIM_RST_WORD;
      end
    end else if (wr_fire && wr_ok && wr_addr[7:5] == BIM_OFS_MAP_BASE[7:5]) begin
      irq_routing_register[wr_addr[4:2]] <=
        merge(irq_routing_register[wr_addr[4:2]], wr_data, wr_mask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < BIM_NUM_MBOX; i++) begin
        mailbox[i] <= BIM_RST_WORD;
      end
    end else if (wr_fire && wr_ok && wr_addr[7:5] == BIM_OFS_MBOX_BASE[7:5]) begin
      mailbox[wr_addr[4:2]] <= merge(mailbox[wr_addr[4:2]], wr_data, wr_mask);
    end
  end

  // Status bits: hardware set wins over a same-cycle write-one clear
  always_ff @(posedge aclk) begin
    logic normal_clr;
    logic [BIM_NUM_MBOX-1:0] mbox_set;
    logic [BIM_NUM_DB-1:0] db_set;
    normal_clr = wr_fire && wr_addr == BIM_OFS_NORMAL_ST;
    mbox_set = '0;
    db_set = '0;
    if (wr_fire && wr_ok && wr_addr[7:5] == BIM_OFS_MBOX_BASE[7:5]) begin
      mbox_set[wr_addr[4:2]] = 1'b1;
    end
    if (wr_fire && wr_addr == BIM_OFS_NORMAL_EN) begin
      db_set = w1[BIM_POS_DB +: BIM_NUM_DB];
    end
    if (!aresetn) begin
      mbox_status <= '0;
      db_status <= '0;
      pin_status <= '0;
      dma_status <= '0;
      iop_status <= 1'b0;
    end else begin
      mbox_status <= (mbox_status & ~(normal_clr ? w1[BIM_POS_MBOX +: BIM_NUM_MBOX] : '0))
        | mbox_set;
      db_status <= (db_status & ~(normal_clr ? w1[BIM_POS_DB +: BIM_NUM_DB] : '0))
        | db_set;
      pin_status <= (pin_status & ~(normal_clr ? w1[BIM_POS_PIN +: BIM_NUM_PINS] : '0))
        | (pin_seen_low & ~direction);
      dma_status <= (dma_status & ~(normal_clr ? w1[BIM_POS_DMA +: BIM_NUM_DMA] : '0))
        | chan_irq;
      iop_status <= (iop_status & ~(normal_clr & w1[BIM_POS_IOP])) | iop_queue_pending;
    end
  end

  always_ff @(posedge aclk) begin
    logic [BIM_NUM_ERR-1:0] err_set;
    err_set = '0;
    for (int p = 0; p < BIM_NUM_PORTS; p++) begin
      if (err_events[p].valid) begin
        err_set[err_index(err_events[p])] = 1'b1;
      end
    end
    if (!aresetn) begin
      error_status <= '0;
    end else begin
      error_status <= (error_status
        & ~((wr_fire && wr_addr == BIM_OFS_ERROR_ST) ? w1[BIM_NUM_ERR-1:0] : '0))
        | err_set;
    end
  end

  genvar g;
  generate
    for (g = 0; g < BIM_NUM_PINS; g++) begin : g_pin
      bim_pin_filter u_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(irq_pin_in[g]),
        .is_input(~direction[g]),
        .seen_low(pin_seen_low[g])
      );
    end
    for (g = 0; g < BIM_NUM_DMA; g++) begin : g_dma
      assign dma_wr[g] = wr_fire && wr_addr == BIM_OFS_DMA_BASE + 8'(4 * g);
      bim_dma_csr u_csr (
        .aclk(aclk),
        .aresetn(aresetn),
        .events(dma_events[g*BIM_DMA_SRCS +: BIM_DMA_SRCS]),
        .csr_wr(dma_wr[g]),
        .csr_wdata(wr_data),
        .csr_wmask(wr_mask),
        .csr_rdata(dma_rdata[g]),
        .chan_irq(chan_irq[g])
      );
    end
  endgenerate

  always_comb begin
    normal_status_word = BIM_RST_WORD;
    normal_status_word[BIM_POS_MBOX +: BIM_NUM_MBOX] = mbox_status;
    normal_status_word[BIM_POS_DB +: BIM_NUM_DB] = db_status;
    normal_status_word[BIM_POS_PIN +: BIM_NUM_PINS] = pin_status;
    normal_status_word[BIM_POS_DMA +: BIM_NUM_DMA] = dma_status;
    normal_status_word[BIM_POS_ERR_ACTV] = |error_status;
    normal_status_word[BIM_POS_IOP] = iop_status;
    normal_status_word[BIM_POS_HOST] = host_queue_pending;
    error_status_word = 32'(error_status);
    // Chained bit must not see its own echo in the other word
    error_status_word[BIM_POS_NORM_ACTV] = |normal_status_word[BIM_POS_ERR_ACTV-1:0]
      | iop_status | host_queue_pending;
  end

  // Pin requests: each routed source gated by its enable; doorbells ungated, host queue blocked while its bit is set
  always_comb begin
    next_drive = '0;
    for (int i = 0; i < BIM_NUM_MBOX; i++) begin
      if (mbox_status[i] && normal_interrupt_enable[BIM_POS_MBOX + i]) begin
        next_drive |= route(irq_routing_register[BIM_MAP_MBOX][BIM_MAP_W*i +: BIM_MAP_W]);
      end
    end
    // Doorbells are always live once set
    for (int i = 0; i < BIM_NUM_DB; i++) begin
      if (db_status[i]) begin
        next_drive |= route(irq_routing_register[BIM_MAP_DB][BIM_MAP_W*i +: BIM_MAP_W]);
      end
    end
    for (int i = 0; i < BIM_NUM_PINS; i++) begin
      if (pin_status[i] && normal_interrupt_enable[BIM_POS_PIN + i]) begin
        next_drive |= route(irq_routing_register[BIM_MAP_PIN][BIM_MAP_W*i +: BIM_MAP_W]);
      end
    end
    for (int i = 0; i < BIM_NUM_DMA; i++) begin
      if (dma_status[i] && normal_interrupt_enable[BIM_POS_DMA + i]) begin
        next_drive |= route(irq_routing_register[BIM_MAP_DMA][BIM_MAP_W*i +: BIM_MAP_W]);
      end
    end
    for (int i = 0; i < BIM_NUM_ERR; i++) begin
      if (error_status[i] && error_interrupt_enable[i]) begin
        next_drive |= route(irq_routing_register[BIM_MAP_PCI_A + i / BIM_ERR_PER_PORT]
          [BIM_MAP_W*(i % BIM_ERR_PER_PORT) +: BIM_MAP_W]);
      end
    end
    if (host_queue_pending && !normal_interrupt_enable[BIM_POS_HOST]) begin
      next_drive |= route(irq_routing_register[BIM_MAP_MISC][2:0]);
    end
    if (iop_status && normal_interrupt_enable[BIM_POS_IOP]) begin
      next_drive |= route(irq_routing_register[BIM_MAP_MISC][5:3]);
    end
  end

  // Open drain: data always low, only the enable moves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_pin_out <= '0;
      irq_pin_oe <= '0;
    end else begin
      irq_pin_out <= '0;
      irq_pin_oe <= next_drive & direction;
    end
  end

  // Read channel: one registered answer per address
  always_comb begin
    rd_ok = addr_ok(s_axi_araddr);
    rd_word = BIM_RST_WORD;
    if (s_axi_araddr == BIM_OFS_NORMAL_EN) begin
      rd_word = normal_interrupt_enable;
    end else if (s_axi_araddr == BIM_OFS_NORMAL_ST) begin
      rd_word = normal_status_word;
    end else if (s_axi_araddr == BIM_OFS_ERROR_EN) begin
      rd_word = error_interrupt_enable;
    end else if (s_axi_araddr == BIM_OFS_ERROR_ST) begin
      rd_word = error_status_word;
    end else if (s_axi_araddr == BIM_OFS_DIRECTION) begin
      rd_word = 32'(direction);
    end else if (rd_ok && s_axi_araddr[7:5] == BIM_OFS_MAP_BASE[7:5]) begin
      rd_word = irq_routing_register[s_axi_araddr[4:2]];
    end else if (rd_ok && s_axi_araddr[7:5] == BIM_OFS_DMA_BASE[7:5]) begin
      rd_word = dma_rdata[s_axi_araddr[3:2]];
    end else if (rd_ok && s_axi_araddr[7:5] == BIM_OFS_MBOX_BASE[7:5]) begin
      rd_word = mailbox[s_axi_araddr[4:2]];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= BIM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_word : BIM_RST_WORD;
      s_axi_rresp <= rd_ok ? BIM_RESP_OKAY : BIM_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : bim_irq_top

//--- pkg/bim_pkg.sv
// Purpose: Shared constants and types for the interrupt enable, routing and pin block
// Assumes: 32-bit AXI4-Lite register access, one clock
// Notes: Pin index 0 is the first PCI line, 1 the second, 2..7 the general pins
package bim_pkg;
  localparam int unsigned BIM_NUM_PINS = 8;
  localparam int unsigned BIM_NUM_DMA = 4;
  localparam int unsigned BIM_NUM_DB = 8;
  localparam int unsigned BIM_NUM_MBOX = 8;
  localparam int unsigned BIM_NUM_PORTS = 3;
  localparam int unsigned BIM_ERR_PER_PORT = 10;
  localparam int unsigned BIM_NUM_ERR = 30;
  localparam int unsigned BIM_DMA_SRCS = 6;
  localparam int unsigned BIM_FILTER_EDGES = 3;

  // Byte offsets
  localparam logic [7:0] BIM_OFS_NORMAL_EN = 8'h00;
  localparam logic [7:0] BIM_OFS_NORMAL_ST = 8'h04;
  localparam logic [7:0] BIM_OFS_ERROR_EN = 8'h08;
  localparam logic [7:0] BIM_OFS_ERROR_ST = 8'h0c;
  localparam logic [7:0] BIM_OFS_DIRECTION = 8'h10;
  localparam logic [7:0] BIM_OFS_MAP_BASE = 8'h20;
  localparam logic [7:0] BIM_OFS_DMA_BASE = 8'h40;
  localparam logic [7:0] BIM_OFS_MBOX_BASE = 8'h60;

  // Routing word index within the map block
  localparam int unsigned BIM_MAP_MBOX = 0;
  localparam int unsigned BIM_MAP_DB = 1;
  localparam int unsigned BIM_MAP_DMA = 2;
  localparam int unsigned BIM_MAP_PIN = 3;
  localparam int unsigned BIM_MAP_PCI_A = 4;
  localparam int unsigned BIM_MAP_PCI_B = 5;
  localparam int unsigned BIM_MAP_CPU = 6;
  localparam int unsigned BIM_MAP_MISC = 7;
  localparam int unsigned BIM_NUM_MAP = 8;
  localparam int unsigned BIM_MAP_W = 3;

  // Normal enable / status field positions; BIM_POS_NORM_ACTV is in the error status word
  localparam int unsigned BIM_POS_MBOX = 0;
  localparam int unsigned BIM_POS_DB = 8;
  localparam int unsigned BIM_POS_PIN = 16;
  localparam int unsigned BIM_POS_DMA = 24;
  localparam int unsigned BIM_POS_ERR_ACTV = 29;
  localparam int unsigned BIM_POS_IOP = 30;
  localparam int unsigned BIM_POS_HOST = 31;
  localparam int unsigned BIM_POS_NORM_ACTV = 31;

  // Error field offsets within one detecting port group
  localparam int unsigned BIM_ERR_RETRY = 0;
  localparam int unsigned BIM_ERR_BUS = 3;
  localparam int unsigned BIM_ERR_DPAR = 6;
  localparam int unsigned BIM_ERR_APAR = 9;

  // DMA channel control-status fields
  localparam int unsigned BIM_DMA_POS_EN = 8;
  localparam int unsigned BIM_DMA_POS_RESTART = 16;

  localparam logic [31:0] BIM_RST_WORD = 32'h0000_0000;
  localparam logic [1:0] BIM_RESP_OKAY = 2'h0;
  localparam logic [1:0] BIM_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BIM_PORT_PCI_A = 2'h0,
    BIM_PORT_PCI_B = 2'h1,
    BIM_PORT_CPU = 2'h2
  } bim_port_e;

  typedef enum logic [1:0] {
    BIM_KIND_RETRY = 2'h0,
    BIM_KIND_BUS = 2'h1,
    BIM_KIND_DPAR = 2'h2,
    BIM_KIND_APAR = 2'h3
  } bim_kind_e;

  typedef struct packed {
    logic valid;
    bim_kind_e kind;
    logic by_master;
    bim_port_e src_port;
    bim_port_e dst_port;
  } bim_err_event_s;

  typedef enum logic [1:0] {
    BIM_WR_IDLE = 2'b01,
    BIM_WR_RESP = 2'b10
  } bim_wr_state_e;
endpackage : bim_pkg

//--- hw/bim_pin_filter.sv
// Purpose: Synchronise one interrupt pin and qualify a low level
// Assumes: Pin is asynchronous to aclk
// Notes: Output is a registered level, high while low seen on three edges
`timescale 1ns/10ps
module bim_pin_filter
  import bim_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_in,
  input wire logic is_input,
  output logic seen_low
);
  logic sync_a;
  logic sync_b;
  logic [BIM_FILTER_EDGES-2:0] hist;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      hist <= '1;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      hist <= {hist[BIM_FILTER_EDGES-3:0], sync_b};
    end
  end

  // Glitch reject: all samples must agree low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_low <= 1'b0;
    end else begin
      seen_low <= is_input & ~sync_b & ~(|hist);
    end
  end
endmodule : bim_pin_filter

//--- hw/bim_dma_csr.sv
// Purpose: Interrupt status and enables of one DMA channel
// Assumes: Events are single-cycle pulses on aclk
// Notes: Restart is allowed only while no source status is pending
`timescale 1ns/10ps
module bim_dma_csr
  import bim_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [BIM_DMA_SRCS-1:0] events,
  input wire logic csr_wr,
  input wire logic [31:0] csr_wdata,
  input wire logic [31:0] csr_wmask,
  output logic [31:0] csr_rdata,
  output logic chan_irq
);
  logic [BIM_DMA_SRCS-1:0] status;
  logic [BIM_DMA_SRCS-1:0] enable;
  logic [BIM_DMA_SRCS-1:0] clr;

  assign clr = csr_wr ? (csr_wdata[BIM_DMA_SRCS-1:0] & csr_wmask[BIM_DMA_SRCS-1:0]) : '0;

  // Set wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
    end else begin
      status <= (status & ~clr) | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable <= '0;
    end else if (csr_wr) begin
      enable <= (enable & ~csr_wmask[BIM_DMA_POS_EN +: BIM_DMA_SRCS])
        | (csr_wdata[BIM_DMA_POS_EN +: BIM_DMA_SRCS]
        & csr_wmask[BIM_DMA_POS_EN +: BIM_DMA_SRCS]);
    end
  end

  assign chan_irq = |(status & enable);
  always_comb begin
    csr_rdata = BIM_RST_WORD;
    csr_rdata[BIM_DMA_SRCS-1:0] = status;
    csr_rdata[BIM_DMA_POS_EN +: BIM_DMA_SRCS] = enable;
    csr_rdata[BIM_DMA_POS_RESTART] = ~(|status);
  end
endmodule : bim_dma_csr

//--- verification/bim_irq_top_asserts.sv
// Purpose: Port checks of the interrupt block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the top module
`timescale 1ns/10ps
module bim_irq_asserts
  import bim_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [BIM_NUM_PINS-1:0] irq_pin_out,
  input wire logic [BIM_NUM_PINS-1:0] irq_pin_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_od; irq_pin_out == 8'h00; endproperty
  a_od: assert property (p_od) else $error("pin data high");
  property p_oe_rst; $rose(aresetn) |-> (irq_pin_oe == 8'h00) [*3]; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("pin driven after reset");
  property p_idle; $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid; endproperty
  a_idle: assert property (p_idle) else $error("answer after reset");
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("bvalid stuck");
  property p_w_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_busy: assert property (p_w_busy) else $error("write taken early");
  property p_ar; s_axi_arready == !s_axi_rvalid; endproperty
  a_ar: assert property (p_ar) else $error("arready wrong");
  property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read late");
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_done: assert property (p_r_done) else $error("rvalid stuck");
endmodule : bim_irq_asserts
bind bim_irq_top bim_irq_asserts bim_irq_asserts_inst (.*);

//--- verification/bim_pin_host.sv
// Purpose: Pull-ups and outside agents on the interrupt lines
// Assumes: Open-drain lines
// Notes: Agents only pull low
`timescale 1ns/10ps
module bim_pin_host
  import bim_pkg::*;
(
  input wire logic [BIM_NUM_PINS-1:0] pin_out,
  input wire logic [BIM_NUM_PINS-1:0] pin_oe,
  input wire logic [BIM_NUM_PINS-1:0] ext_low,
  output logic [BIM_NUM_PINS-1:0] pin_level
);
  // Released line floats up, never keeps its last value
  assign pin_level = ~((pin_oe & ~pin_out) | ext_low);
endmodule : bim_pin_host

//--- verification/testbench.sv
// Purpose: Self-checking bench of the interrupt block
// Assumes: Pull-ups on all lines
// Notes: Reads checked by a monitor against queued notes
`timescale 1ns/10ps
module testbench
  import bim_pkg::*;
;
  logic aclk = '0, aresetn = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
  logic s_axi_rvalid, s_axi_rready = '0, host_queue_pending = '0, iop_queue_pending = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, irq_pin_in, irq_pin_out, irq_pin_oe;
  logic [7:0] ext_low = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] dma_events = '0;
  bim_err_event_s [2:0] err_events = '0;
  logic [33:0] exp_q[$];
  int fail_count = 0, compares = 0;
  bim_irq_top bim_irq_top_inst (.*);
  bim_pin_host bim_pin_host_inst (.pin_out(irq_pin_out), .pin_oe(irq_pin_oe), .ext_low(ext_low),
    .pin_level(irq_pin_in));
  initial forever #4 aclk = ~aclk;
  task automatic bad(input string m);
    fail_count++;
    $display("Error at %0t: %s", $time, m);
  endtask : bad
  task automatic final_report;
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    logic ah, wh, bh;
    logic [1:0] br;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    do begin
      // Negedge values are what the next rising edge samples
      @(negedge aclk) {ah, wh, bh, br} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge aclk) {s_axi_awvalid, s_axi_wvalid} <= {s_axi_awvalid & ~ah, s_axi_wvalid & ~wh};
    end while (!bh);
    s_axi_bready <= '0;
    compares++;
    if (br !== r) bad("write response");
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    logic ah, rh;
    @(posedge aclk);
    exp_q.push_back({r, e});
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(negedge aclk) {ah, rh} = {s_axi_arready, s_axi_rvalid};
      @(posedge aclk) s_axi_arvalid <= s_axi_arvalid & ~ah;
    end while (!rh);
    s_axi_rready <= '0;
  endtask : axr
  task automatic pins(input logic [7:0] e);
    repeat (4) @(negedge aclk);
    compares++;
    if (irq_pin_in !== e) bad("pin level");
  endtask : pins
  always @(negedge aclk) if (s_axi_rvalid && s_axi_rready) begin
    compares++;
    if ({s_axi_rresp, s_axi_rdata} !== exp_q.pop_front()) bad("read data");
  end
  initial begin
    repeat (20000) @(posedge aclk);
    bad("timeout");
    final_report;
  end
  initial begin
    v = $urandom(96);
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (int a = 0; a < 20; a += 4) axr(8'(a), '0);
    axr(8'h14, '0, BIM_RESP_SLVERR);
    axw(8'h14, 32'h1, BIM_RESP_SLVERR);
    v = $urandom & 32'hcfff00ff;
    axw(8'h00, v);
    axr(8'h00, v);
    v = $urandom & 32'h3fffffff;
    axw(8'h08, v);
    axr(8'h08, v);
    axw(8'h00, '0);
    $display("Test registers done");
    axw(8'h10, 32'h4);
    for (int a = 32; a < 64; a += 4) axw(8'(a), 32'h2);
    v = $urandom;
    axw(8'h60, v);
    axr(8'h60, v);
    axr(8'h04, 32'h1);
    pins(8'hff);
    axw(8'h00, 32'h1);
    pins(8'hfb);
    axw(8'h04, 32'h1);
    pins(8'hff);
    $display("Test mailbox done");
    axw(8'h10, 32'hff);
    for (int c = 0; c < 8; c++) begin
      axw(8'h24, 32'(c));
      axw(8'h00, 32'h100);
      pins(~(8'h01 << c));
      axw(8'h04, 32'h100);
      pins(8'hff);
    end
    axr(8'h00, '0);
    axw(8'h10, 32'h4);
    $display("Test routing done");
    axw(8'h40, 32'h100);
    axw(8'h00, 32'h0100_0000);
    @(posedge aclk) dma_events <= 24'h3f;
    @(posedge aclk) dma_events <= '0;
    pins(8'hfb);
    axr(8'h04, 32'h0100_0000);
    axr(8'h40, 32'h13f);
    axw(8'h40, 32'h13f);
    axr(8'h40, 32'h1_0100);
    axw(8'h04, 32'h0100_0000);
    pins(8'hff);
    $display("Test dma done");
    @(posedge aclk) host_queue_pending <= 1'h1;
    pins(8'hfb);
    axr(8'h04, 32'h8000_0000);
    axw(8'h00, 32'h8000_0000);
    pins(8'hff);
    @(posedge aclk) host_queue_pending <= '0;
    @(posedge aclk) iop_queue_pending <= 1'h1;
    @(posedge aclk) iop_queue_pending <= '0;
    axr(8'h04, 32'h4000_0000);
    axw(8'h04, 32'h4000_0000);
    axr(8'h04, '0);
    $display("Test host done");
    for (int k = 2; k < 4; k++) begin
      @(posedge aclk) ext_low <= 8'h20;
      repeat (k) @(posedge aclk);
      ext_low <= '0;
      repeat (8) @(posedge aclk);
      axr(8'h04, k == 3 ? 32'h20_0000 : '0);
    end
    axw(8'h04, 32'h20_0000);
    $display("Test pin input done");
    @(posedge aclk) err_events[0] <= {1'h1, BIM_KIND_RETRY, 1'h1, BIM_PORT_PCI_B, BIM_PORT_CPU};
    @(posedge aclk) err_events <= '0;
    axr(8'h0c, 32'h20_0000);
    axw(8'h0c, 32'h20_0000);
    @(posedge aclk) err_events[1] <= {1'h1, BIM_KIND_DPAR, 1'h0, BIM_PORT_PCI_A, BIM_PORT_CPU};
    @(posedge aclk) err_events <= '0;
    axr(8'h0c, 32'h100);
    $display("Test errors done");
    final_report;
  end
endmodule : testbench
